// ### core/lomre_regs.svh
// lomre_regs.svh: constants for the literal/or/move/rotate execution block
// assumes: included by bare name from the package and design modules
`ifndef LOMRE_REGS_SVH
`define LOMRE_REGS_SVH
`define LOMRE_DATA_W      8
`define LOMRE_ADDR_W      7
`define LOMRE_PC_W        13
`define LOMRE_ACC_RST     8'h00
`define LOMRE_PC_RST      13'h0000
`define LOMRE_ZERO_RST    1'b0
`define LOMRE_CARRY_RST   1'b0
`define LOMRE_GIA_RST     1'b0
`define LOMRE_DEST_ACC    1'b0
`define LOMRE_DEST_FILE   1'b1
`endif

// ### core/lomre_pkg.sv
// lomre_pkg.sv: types shared by the execution datapath
// assumes: lomre_regs.svh is on the include path
`include "lomre_regs.svh"
package lomre_pkg;
   // operations delivered by the instruction decoder
   typedef enum logic [3:0] {
      LOMRE_OP_NOP,
      LOMRE_OP_OR_LITERAL_INTO_ACC,
      LOMRE_OP_LOAD_LITERAL_ACC,
      LOMRE_OP_OR_ACC_WITH_FILE,
      LOMRE_OP_STORE_ACC_TO_FILE,
      LOMRE_OP_MOVE_FILE_REG,
      LOMRE_OP_ROTATE_LEFT_THROUGH_CARRY,
      LOMRE_OP_RETURN_FROM_IRQ
   } lomre_op_type;

   // decoded instruction with its operands
   typedef struct packed {
      logic                       valid;
      lomre_op_type               op;
      logic [`LOMRE_DATA_W-1:0]   literal;
      logic [`LOMRE_ADDR_W-1:0]   addr;
      logic                       dest;
   } lomre_instr_type;

   // file register write request
   typedef struct packed {
      logic                       we;
      logic [`LOMRE_ADDR_W-1:0]   addr;
      logic [`LOMRE_DATA_W-1:0]   data;
   } lomre_fwr_type;

   // combinational result of one instruction
   typedef struct packed {
      logic                       acc_we;
      logic                       file_we;
      logic                       zero_we;
      logic                       carry_we;
      logic                       ret_irq;
      logic [`LOMRE_DATA_W-1:0]   result;
      logic                       carry_new;
   } lomre_res_type;
endpackage : lomre_pkg

// ### core/lomre_alu.sv
// lomre_alu.sv: combinational result and write-enable decode
// assumes: operands stable for the whole cycle, same clock as the top
`timescale 1ns/100ps
`include "lomre_regs.svh"
module lomre_alu
   import lomre_pkg::*;
(
   input  wire lomre_instr_type          instr,     // decoded instruction
   input  wire logic [`LOMRE_DATA_W-1:0] acc,       // accumulator value
   input  wire logic [`LOMRE_DATA_W-1:0] fdata,     // addressed file data
   input  wire logic                     carry,     // rotate_out_bit
   output lomre_res_type                 res        // result and enables
);
   //////////////////////////////////////////////////////////////////////
   // operation selection
   wire is_orl  = instr.valid && instr.op == LOMRE_OP_OR_LITERAL_INTO_ACC;
   wire is_ldl  = instr.valid && instr.op == LOMRE_OP_LOAD_LITERAL_ACC;
   wire is_orf  = instr.valid && instr.op == LOMRE_OP_OR_ACC_WITH_FILE;
   wire is_st   = instr.valid && instr.op == LOMRE_OP_STORE_ACC_TO_FILE;
   wire is_mov  = instr.valid && instr.op == LOMRE_OP_MOVE_FILE_REG;
   wire is_rl   = instr.valid &&
                  instr.op == LOMRE_OP_ROTATE_LEFT_THROUGH_CARRY;
   wire is_rti  = instr.valid && instr.op == LOMRE_OP_RETURN_FROM_IRQ;
   wire has_dst = is_orf || is_mov || is_rl;    // carries destination bit

   // result values per operation
   wire [`LOMRE_DATA_W-1:0] orl_v = acc | instr.literal;
   wire [`LOMRE_DATA_W-1:0] orf_v = acc | fdata;
   wire [`LOMRE_DATA_W-1:0] rl_v  =
      {fdata[`LOMRE_DATA_W-2:0], carry};

   //////////////////////////////////////////////////////////////////////
   // result mux and write enables
   assign res.result  = is_orl ? orl_v :
                        is_ldl ? instr.literal :
                        is_orf ? orf_v :
                        is_st  ? acc :
                        is_rl  ? rl_v :
                        fdata;
   assign res.carry_new = fdata[`LOMRE_DATA_W-1];
   // destination select for f,d instructions
   assign res.acc_we  = is_orl || is_ldl ||
                        (has_dst && instr.dest == `LOMRE_DEST_ACC);
   assign res.file_we = is_st ||
                        (has_dst && instr.dest == `LOMRE_DEST_FILE);
   // only or and move touch the zero flag; nop touches nothing
   assign res.zero_we  = is_orl || is_orf || is_mov;
   assign res.carry_we = is_rl;
   assign res.ret_irq  = is_rti;
endmodule // lomre_alu

// ### core/lomre_exec.sv
// lomre_exec.sv: execution datapath top for or/literal/move/rotate ops
// assumes: decoder supplies one instruction per clk with fdata already
// read combinationally from the addressed file register; the stack
// supplies stack_top_value; all inputs are on clk, no synchroniser
`timescale 1ns/100ps
`include "lomre_regs.svh"
module lomre_exec
   import lomre_pkg::*;
(
   input  wire logic                     clk,             // 125 MHz
   input  wire logic                     rst_b,           // async, low
   input  wire lomre_instr_type          instr,           // from decoder
   input  wire logic [`LOMRE_DATA_W-1:0] fdata,           // file read data
   input  wire logic [`LOMRE_PC_W-1:0]   stack_top_value, // return address
   input  wire logic                     gia_clear,       // irq entry clear
   output lomre_fwr_type                 fwr,             // file write
   output logic [`LOMRE_DATA_W-1:0]      acc,             // accumulator
   output logic                          result_nil_flag, // zero flag
   output logic                          rotate_out_bit,  // carry flag
   output logic                          global_interrupt_allow,
   output logic [`LOMRE_PC_W-1:0]        pc_load_value,   // pc target
   output logic                          pc_load          // pc load pulse
);
   //////////////////////////////////////////////////////////////////////
   // combinational result
   lomre_res_type res;   // result and enables

   lomre_alu u_alu (
      .instr (instr),
      .acc   (acc),
      .fdata (fdata),
      .carry (rotate_out_bit),
      .res   (res)
   );

   wire zero_v = (res.result == '0);   // nil detect

   //////////////////////////////////////////////////////////////////////
   // accumulator
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         acc <= `LOMRE_ACC_RST;
      end else if (res.acc_we) begin
         acc <= res.result;
      end
   end

   // file register write port, registered
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         fwr <= '0;
      end else begin
         fwr.we   <= res.file_we;
         fwr.addr <= instr.addr;
         fwr.data <= res.result;
      end
   end

   //////////////////////////////////////////////////////////////////////
   // status flags
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         result_nil_flag <= `LOMRE_ZERO_RST;
         rotate_out_bit  <= `LOMRE_CARRY_RST;
      end else begin
         if (res.zero_we) begin
            result_nil_flag <= zero_v;
         end
         if (res.carry_we) begin
            rotate_out_bit <= res.carry_new;
         end
      end
   end

   // interrupt allow: return sets, set wins over a simultaneous clear
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         global_interrupt_allow <= `LOMRE_GIA_RST;
      end else if (res.ret_irq) begin
         global_interrupt_allow <= 1'b1;
      end else if (gia_clear) begin
         global_interrupt_allow <= 1'b0;
      end
   end

   // program counter load on return
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pc_load       <= 1'b0;
         pc_load_value <= `LOMRE_PC_RST;
      end else begin
         pc_load       <= res.ret_irq;
         pc_load_value <= res.ret_irq ? stack_top_value : pc_load_value;
      end
   end

   //////////////////////////////////////////////////////////////////////
   // assertions
   sequence s_or_lit;
      instr.valid && instr.op == LOMRE_OP_OR_LITERAL_INTO_ACC;
   endsequence

   property p_or_lit;
      @(posedge clk) disable iff (!rst_b)
      s_or_lit |=> acc == ($past(acc) | $past(instr.literal)) &&
                   result_nil_flag == (acc == 8'h00);
   endproperty
   a_or_lit: assert property (p_or_lit)
      else $error("or literal result wrong");

   property p_ld_lit;
      @(posedge clk) disable iff (!rst_b)
      (instr.valid && instr.op == LOMRE_OP_LOAD_LITERAL_ACC) |=>
         acc == $past(instr.literal) && $stable(result_nil_flag) &&
         $stable(rotate_out_bit);
   endproperty
   a_ld_lit: assert property (p_ld_lit)
      else $error("load literal wrong");

   property p_or_file;
      @(posedge clk) disable iff (!rst_b)
      (instr.valid && instr.op == LOMRE_OP_OR_ACC_WITH_FILE) |=>
         result_nil_flag == (($past(acc) | $past(fdata)) == 8'h00);
   endproperty
   a_or_file: assert property (p_or_file)
      else $error("or file zero flag wrong");

   property p_dest_file;
      @(posedge clk) disable iff (!rst_b)
      (instr.valid && instr.dest &&
       (instr.op == LOMRE_OP_OR_ACC_WITH_FILE ||
        instr.op == LOMRE_OP_MOVE_FILE_REG)) |=>
         fwr.we && fwr.addr == $past(instr.addr) && $stable(acc);
   endproperty
   a_dest_file: assert property (p_dest_file)
      else $error("dest 1 did not write file");

   property p_store;
      @(posedge clk) disable iff (!rst_b)
      (instr.valid && instr.op == LOMRE_OP_STORE_ACC_TO_FILE) |=>
         fwr.we && fwr.data == $past(acc) && $stable(result_nil_flag);
   endproperty
   a_store: assert property (p_store)
      else $error("store acc wrong");

   property p_move_acc;
      @(posedge clk) disable iff (!rst_b)
      (instr.valid && instr.op == LOMRE_OP_MOVE_FILE_REG && !instr.dest)
         |=> acc == $past(fdata) && !fwr.we;
   endproperty
   a_move_acc: assert property (p_move_acc)
      else $error("move to acc wrong");

   property p_rotate;
      @(posedge clk) disable iff (!rst_b)
      (instr.valid && instr.op == LOMRE_OP_ROTATE_LEFT_THROUGH_CARRY) |=>
         rotate_out_bit == $past(fdata[7]) &&
         fwr.data == {$past(fdata[6:0]), $past(rotate_out_bit)};
   endproperty
   a_rotate: assert property (p_rotate)
      else $error("rotate wrong");

   // rotate result lands in acc or file, never both
   property p_rot_dest;
      @(posedge clk) disable iff (!rst_b)
      (instr.valid && instr.op == LOMRE_OP_ROTATE_LEFT_THROUGH_CARRY) |=>
         fwr.we == $past(instr.dest) &&
         ($past(instr.dest) ? $stable(acc) : acc == fwr.data);
   endproperty
   a_rot_dest: assert property (p_rot_dest)
      else $error("rotate destination wrong");

   // return from irq taken at this edge
   sequence s_rti;
      instr.valid && instr.op == LOMRE_OP_RETURN_FROM_IRQ;
   endsequence

   // pulse drops next cycle unless another return follows directly
   property p_rti;
      @(posedge clk) disable iff (!rst_b)
      s_rti |=>
         pc_load && global_interrupt_allow &&
         pc_load_value == $past(stack_top_value) ##1
         pc_load == $past(instr.valid &&
                          instr.op == LOMRE_OP_RETURN_FROM_IRQ);
   endproperty
   a_rti: assert property (p_rti)
      else $error("return from irq wrong");

   property p_nop;
      @(posedge clk) disable iff (!rst_b)
      (!instr.valid || instr.op == LOMRE_OP_NOP) |=>
         $stable(acc) && !fwr.we && $stable(result_nil_flag) &&
         $stable(rotate_out_bit);
   endproperty
   a_nop: assert property (p_nop)
      else $error("nop changed state");

   // return leaves acc, flags and file alone
   property p_rti_flags;
      @(posedge clk) disable iff (!rst_b)
      s_rti |=> $stable(acc) && $stable(result_nil_flag) &&
                $stable(rotate_out_bit) && !fwr.we;
   endproperty
   a_rti_flags: assert property (p_rti_flags)
      else $error("return changed data state");

   // move back to file: same value written, zero flag refreshed
   property p_move_file;
      @(posedge clk) disable iff (!rst_b)
      (instr.valid && instr.op == LOMRE_OP_MOVE_FILE_REG && instr.dest)
         |=> fwr.data == $past(fdata) &&
             result_nil_flag == ($past(fdata) == 8'h00);
   endproperty
   a_move_file: assert property (p_move_file)
      else $error("move to file wrong");

   // clear only takes effect when no return sets the allow bit
   property p_gia_clear;
      @(posedge clk) disable iff (!rst_b)
      (gia_clear && !(instr.valid && instr.op == LOMRE_OP_RETURN_FROM_IRQ))
         |=> !global_interrupt_allow;
   endproperty
   a_gia_clear: assert property (p_gia_clear)
      else $error("interrupt allow clear wrong");
endmodule // lomre_exec

// ### testbench/lomre_file_model.sv
// lomre_file_model.sv: behavioural file register array for the bench
// assumes: fwr writes land on clk; reads are combinational from addr
`timescale 1ns/100ps
`include "lomre_regs.svh"
module lomre_file_model
   import lomre_pkg::*;
(
   input  wire logic                     clk,   // core clock
   input  wire lomre_instr_type          instr, // current instruction
   input  wire lomre_fwr_type            fwr,   // write from the block
   output logic [`LOMRE_DATA_W-1:0]      fdata  // addressed read data
);
   logic [`LOMRE_DATA_W-1:0] mem [0:127]; // file contents

   // fixed start pattern, mirrored by the bench model
   initial begin
      for (int i = 0; i < 128; i++) mem[i] = 8'(i * 37);
   end

   // write lands at the edge after the one that shows the request
   always @(posedge clk) begin
      if (fwr.we === 1'b1) mem[fwr.addr] <= fwr.data;
   end

   // bypass a write still pending for the same address
   assign fdata = (fwr.we === 1'b1 && fwr.addr === instr.addr) ?
                  fwr.data : mem[instr.addr];
endmodule // lomre_file_model

// ### testbench/literal_or_move_rotate_exec_tb.sv
// literal_or_move_rotate_exec_tb.sv: random self-checking bench
// assumes: lomre_pkg compiled first, file model beside the block
`timescale 1ns/100ps
`include "lomre_regs.svh"
module literal_or_move_rotate_exec_tb;
   import lomre_pkg::*;
   logic            clk = 1'b0;      // starts low: no false edge at 0
   logic            rst_b, gia_clear;
   lomre_instr_type instr;           // driven instruction
   logic [7:0]      fdata, acc;      // file read, accumulator
   logic [12:0]     stack_top_value, pc_load_value;
   lomre_fwr_type   fwr;             // file write from the block
   logic            result_nil_flag, rotate_out_bit;
   logic            global_interrupt_allow, pc_load;
   int n_fail, samples_checked, cyc;
   int m_acc, m_z, m_c, m_gia, m_pcv, m_pcl, m_we, m_wa, m_wd;
   int fm [128];                     // bench copy of the file

   ////////////////////////////////////////////////////////////////////
   lomre_exec dut (.clk(clk), .rst_b(rst_b), .instr(instr),
      .fdata(fdata), .stack_top_value(stack_top_value),
      .gia_clear(gia_clear), .fwr(fwr), .acc(acc),
      .result_nil_flag(result_nil_flag), .rotate_out_bit(rotate_out_bit),
      .global_interrupt_allow(global_interrupt_allow),
      .pc_load_value(pc_load_value), .pc_load(pc_load));
   lomre_file_model files (.clk(clk), .instr(instr), .fwr(fwr),
      .fdata(fdata));

   ////////////////////////////////////////////////////////////////////
   task chk(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task give_verdict;
      $display("checked %0d failed %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   // route a result by the destination bit
   task put(input int r);
      if (instr.dest) begin
         m_we = 1; m_wa = instr.addr; m_wd = r; fm[instr.addr] = r;
      end else m_acc = r;
   endtask

   // reference effect of the instruction now on the inputs
   task model;
      int f, r;
      f = fm[instr.addr];
      m_we = 0;
      m_pcl = 0;
      if (instr.valid === 1'b1) case (instr.op)
         LOMRE_OP_OR_LITERAL_INTO_ACC: begin
            m_acc = m_acc | instr.literal; m_z = (m_acc == 0);
         end
         LOMRE_OP_LOAD_LITERAL_ACC: m_acc = instr.literal;
         LOMRE_OP_OR_ACC_WITH_FILE: begin
            r = m_acc | f; m_z = (r == 0); put(r);
         end
         LOMRE_OP_STORE_ACC_TO_FILE: begin
            m_we = 1; m_wa = instr.addr; m_wd = m_acc;
            fm[instr.addr] = m_acc;
         end
         LOMRE_OP_MOVE_FILE_REG: begin
            m_z = (f == 0); put(f);
         end
         LOMRE_OP_ROTATE_LEFT_THROUGH_CARRY: begin
            r = ((f << 1) | m_c) & 255; m_c = f >> 7; put(r);
         end
         LOMRE_OP_RETURN_FROM_IRQ: begin
            m_pcl = 1; m_pcv = stack_top_value; m_gia = 1;
         end
         default: ;
      endcase
      if (m_pcl == 0 && gia_clear) m_gia = 0;
   endtask

   ////////////////////////////////////////////////////////////////////
   // clock, 8 ns period
   initial begin
      clk = 0;
      forever #4 clk = ~clk;
   end

   // outputs checked mid-cycle, then the model advances
   always @(negedge clk) begin
      chk(acc, 16'(m_acc));
      chk(result_nil_flag, 16'(m_z));
      chk(rotate_out_bit, 16'(m_c));
      chk(global_interrupt_allow, 16'(m_gia));
      chk(pc_load, 16'(m_pcl));
      chk(pc_load_value, 16'(m_pcv));
      chk(fwr.we, 16'(m_we));
      if (m_we) chk({fwr.addr, fwr.data}, {7'(m_wa), 8'(m_wd)});
      if (rst_b) model;
   end

   // hang guard
   always @(posedge clk) begin
      cyc++;
      if (cyc > 2000) begin
         n_fail++;
         give_verdict;
      end
   end

   // reset, then random instruction stream
   initial begin
      rst_b = 0; instr = '0; stack_top_value = 0; gia_clear = 0;
      n_fail = 0; samples_checked = 0; cyc = 0;
      {m_acc, m_z, m_c, m_gia, m_pcv, m_pcl, m_we, m_wa, m_wd} = '0;
      for (int i = 0; i < 128; i++) fm[i] = (i * 37) & 255;
      void'($urandom(70098));
      repeat (20) @(posedge clk);
      rst_b <= 1;
      repeat (600) begin
         @(posedge clk);
         // narrow addresses force back-to-back hits; ops 8,9 unknown
         instr <= '{valid: ($urandom % 8 != 0),
                    op: lomre_op_type'(4'($urandom % 10)),
                    literal: ($urandom % 4 == 0) ? 8'h00 : 8'($urandom),
                    addr: 7'($urandom % 8), dest: 1'($urandom)};
         stack_top_value <= 13'($urandom);
         gia_clear <= ($urandom % 8 == 0);
      end
      @(posedge clk);
      instr <= '0;
      repeat (3) @(posedge clk);
      give_verdict;
   end
endmodule // literal_or_move_rotate_exec_tb
